// ===== rtl/cycle_timer.sv
`timescale 1ns/10ps
module cycle_timer
    import sar_adc_pkg::*;
#(
    parameter int W = 8,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic busy
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } tmr_t;

    tmr_t q;
    tmr_t d;

    // Count down to zero, reload wins
    always_comb begin
        d = q;
        if (load) begin
            d.cnt = load_val;
        end else if (q.cnt != '0) begin
            d.cnt = q.cnt - W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q.cnt <= INIT;
        end else begin
            q <= d;
        end
    end

    assign busy = (q.cnt != '0);
endmodule

// ===== rtl/sar_adc_pkg.sv
package sar_adc_pkg;

    // Byte offsets of the register words
    localparam logic [7:0] ADDR_CTL = 8'h00;
    localparam logic [7:0] ADDR_OPT = 8'h04;
    localparam logic [7:0] ADDR_RES1 = 8'h08;
    localparam logic [7:0] ADDR_RES2 = 8'h0c;
    localparam logic [7:0] ADDR_RES3 = 8'h10;
    localparam logic [7:0] ADDR_RES4 = 8'h14;

    // Control/status field positions
    localparam int CTL_FLAG_BIT = 7;
    localparam int CTL_SCAN_BIT = 5;
    localparam int CTL_MULTI_INPUT_SELECT_BIT = 4;

    // Options field positions and masks
    localparam int OPT_PWR_BIT = 7;
    localparam int OPT_CONV_CLOCK_SOURCE_BIT = 6;
    localparam int OPT_DLY_BIT = 4;
    localparam logic [7:0] OPT_RW_MASK = 8'hfb;
    localparam logic [7:0] OPT_PROT_MASK = 8'h33;
    localparam logic [7:0] OPT_RESET = 8'h00;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // Conversion timing in converter clock steps
    localparam logic [4:0] SAMPLE_CYC = 5'd12;
    localparam logic [4:0] DECIDE_LAST_CYC = 5'd27;
    localparam logic [4:0] CONV_LAST_CYC = 5'd31;
    localparam logic [1:0] SEQ_LAST = 2'd3;
    localparam logic [7:0] SAR_MSB = 8'h80;

    // Cycle counts on aclk (E clock)
    localparam logic [11:0] STOP_LONG_CYC = 12'd4000;
    localparam logic [11:0] STOP_SHORT_CYC = 12'd4;
    localparam logic [6:0] PROT_WIN_CYC = 7'd64;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_CONV, ST_STORE} seq_state_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;

    typedef struct packed {
        logic [15:0] route;
        logic [3:0] chan;
        logic sample_on;
        logic [7:0] dac;
        logic power_on;
        logic rc_clock_sel;
    } ana_out_t;

endpackage

// ===== rtl/sar_adc_sequencer.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Exactly one of 16 mux inputs is routed, picked by the select field (multi channel: its high bits and the index).
// - Codes 0-7 are external inputs; 12-14 references; others reserved.
// - Eight comparison steps per conversion, most significant bit first.
// - A finished conversion is copied into its own result register.
// - Sampling switch closes only in the first twelve steps.
// - Options bit 7 powers converter and charge pump; clear disables it.
// - Four readable 8-bit results; a flag tells when all are valid.
// - Result stores never happen in a cycle that takes a read.
// - Clock-select bit: 0 uses E clock, 1 uses RC oscillator ticks.
// - Sequences of four, repeated or single pass per scan bit.
// - Done flag sets after fourth result of a sequence is stored.
// - Sequence starts one cycle after a control write, new settings.
// - Low reference gives 00, high gives ff, no overflow signal.
// - Stop exit waits 4000 cycles if delay bit set, else four.
// - Protected option bits take one write in first 64 cycles, any number in special mode.
// - Control bits pick input, scan, single/multi channel, show status.
// - Single channel, no scan: four conversions to results 1-4, halt.
// - Scan on: conversions continue, fifth result overwrites first.
// - Multi channel: high select bits choose group of four inputs.
// - Control write clears done flag and restarts the sequence.
module sar_adc_sequencer
    import sar_adc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire axil_req_t axi_req,
    output axil_rsp_t axi_rsp,
    input wire logic comp_high,
    input wire logic rc_tick,
    input wire logic stop_mode,
    input wire logic special_mode,
    output ana_out_t ana_out,
    output logic cpu_resume_ok
);
    // All state except the timers and SAR in one record, registered in one place
    typedef struct packed {
        logic [3:0] sel;
        logic scan;
        logic multi_input_select;
        logic flag;
        logic [7:0] opt;
        logic prot_used;
        logic [3:0][7:0] res;
        seq_state_t st;
        logic [1:0] idx;
        logic [4:0] cyc;
        logic aw_held;
        logic [7:0] awaddr;
        logic w_held;
        logic [7:0] wdata;
        logic wlane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic stop_q;
    } state_t;

    state_t q;
    state_t d;

    // Glue between the state record, the timers and the SAR
    logic win_open;
    logic stop_busy;
    logic stop_exit;
    logic [11:0] stop_len;
    logic resume_ok;
    logic step;
    logic sar_clear;
    logic sar_decide;
    logic [7:0] sar_trial;
    logic [7:0] sar_result;
    logic [3:0] cur_chan;
    logic rd_take;
    logic wr_go;
    logic [7:0] ctl_word;

    // Window after reset in which protected bits may be set once
    cycle_timer #(
        .W(7),
        .INIT(PROT_WIN_CYC)
    ) u_prot_win (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(1'b0),
        .load_val(7'h00),
        .busy(win_open)
    );

    // Oscillator start-up wait after leaving stop
    assign stop_exit = q.stop_q && !stop_mode;
    assign stop_len = q.opt[OPT_DLY_BIT] ? STOP_LONG_CYC : STOP_SHORT_CYC;

    cycle_timer #(
        .W(12),
        .INIT(12'h000)
    ) u_stop_wait (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(stop_exit),
        .load_val(stop_len),
        .busy(stop_busy)
    );

    // CPU and converter both wait out the exit delay
    assign resume_ok = !stop_mode && !stop_busy && !stop_exit;
    assign cpu_resume_ok = resume_ok;

    // Successive approximation register and its trial code
    sar_core u_sar (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(sar_clear),
        .decide(sar_decide),
        .comp_high(comp_high),
        .trial(sar_trial),
        .result(sar_result)
    );

    // Converter step: every E clock, or only on RC ticks
    assign step = !q.opt[OPT_CONV_CLOCK_SOURCE_BIT] || rc_tick;

    // Group mode keeps the high select bits, index fills the low pair
    assign cur_chan = q.multi_input_select ? {q.sel[3:2], q.idx} : q.sel;

    // Odd steps 13..27 each settle one bit
    assign sar_decide = (q.st == ST_CONV) && step && resume_ok
                        && q.opt[OPT_PWR_BIT]
                        && (q.cyc > SAMPLE_CYC) && q.cyc[0]
                        && (q.cyc <= DECIDE_LAST_CYC);

    // One read and one write in flight; address may lead or trail data
    assign rd_take = axi_req.arvalid && !q.rvalid;
    assign wr_go = q.aw_held && q.w_held && !q.bvalid;

    // Status word as software reads it; bit 6 always reads zero
    assign ctl_word = {q.flag, 1'b0, q.scan, q.multi_input_select, q.sel};

    // Analog side controls
    always_comb begin
        ana_out.route = 16'h0001 << cur_chan;
        ana_out.chan = cur_chan;
        ana_out.sample_on = (q.st == ST_CONV) && (q.cyc < SAMPLE_CYC)
                            && q.opt[OPT_PWR_BIT];
        ana_out.dac = sar_trial;
        ana_out.power_on = q.opt[OPT_PWR_BIT];
        ana_out.rc_clock_sel = q.opt[OPT_CONV_CLOCK_SOURCE_BIT];
    end

    // Handshake outputs straight from held state
    always_comb begin
        axi_rsp.awready = !q.aw_held && !q.bvalid;
        axi_rsp.wready = !q.w_held && !q.bvalid;
        axi_rsp.bvalid = q.bvalid;
        axi_rsp.bresp = q.bresp;
        axi_rsp.arready = !q.rvalid;
        axi_rsp.rvalid = q.rvalid;
        axi_rsp.rdata = {24'h000000, q.rdata};
        axi_rsp.rresp = q.rresp;
    end

    // Bus slave, sequencer and register file in one next-state block
    always_comb begin
        logic [7:0] wmask;
        logic prot_ok;
        logic start;
        d = q;
        wmask = 8'h00;
        prot_ok = 1'b0;
        start = 1'b0;
        sar_clear = 1'b0;
        // Last stop level, to catch the exit edge
        d.stop_q = stop_mode;

        // Address and data may come in either order
        if (axi_req.awvalid && axi_rsp.awready) begin
            d.aw_held = 1'b1;
            d.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && axi_rsp.wready) begin
            d.w_held = 1'b1;
            d.wdata = axi_req.wdata[7:0];
            d.wlane0 = axi_req.wstrb[0];
        end
        if (q.bvalid && axi_req.bready) begin
            d.bvalid = 1'b0;
        end

        // Sequencer
        case (q.st)
            ST_IDLE: begin
                // Parked until the next control write
            end
            ST_ARM: begin
                // Also re-entered to resample after stop
                if (q.opt[OPT_PWR_BIT] && resume_ok) begin
                    d.st = ST_CONV;
                    d.cyc = 5'd0;
                    sar_clear = 1'b1;
                end
            end
            ST_CONV: begin
                // Stop suspends; the channel is resampled on resume
                if (!resume_ok) begin
                    d.st = ST_ARM;
                end else if (step) begin
                    if (q.cyc == CONV_LAST_CYC) begin
                        d.st = ST_STORE;
                    end else begin
                        d.cyc = q.cyc + 5'd1;
                    end
                end
            end
            ST_STORE: begin
                // Hold off a store while a read is being taken
                if (!rd_take) begin
                    d.res[q.idx] = sar_result;
                    if (q.idx == SEQ_LAST) begin
                        d.flag = 1'b1;
                    end
                    if (q.idx == SEQ_LAST && !q.scan) begin
                        d.st = ST_IDLE;
                    end else begin
                        // Two-bit index wraps to result one in scan mode
                        d.idx = q.idx + 2'd1;
                        d.st = ST_CONV;
                        d.cyc = 5'd0;
                        sar_clear = 1'b1;
                    end
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        // Power removed halts the converter sequence
        // Parked in arm so a later power-up resumes the sequence
        if (!q.opt[OPT_PWR_BIT] && q.st != ST_IDLE && q.st != ST_ARM) begin
            d.st = ST_ARM;
        end

        // Register write once both halves are held
        if (wr_go) begin
            // Free both halves so the next write starts clean
            d.aw_held = 1'b0;
            d.w_held = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            case (q.awaddr)
                ADDR_CTL: begin
                    if (q.wlane0) begin
                        d.sel = q.wdata[3:0];
                        d.scan = q.wdata[CTL_SCAN_BIT];
                        d.multi_input_select = q.wdata[CTL_MULTI_INPUT_SELECT_BIT];
                        start = 1'b1;
                    end
                end
                ADDR_OPT: begin
                    if (q.wlane0) begin
                        // Outside special mode, late writes only reach the unprotected bits
                        prot_ok = special_mode
                                  || (win_open && !q.prot_used);
                        wmask = prot_ok ? OPT_RW_MASK
                                        : (OPT_RW_MASK & ~OPT_PROT_MASK);
                        d.opt = (q.opt & ~wmask) | (q.wdata & wmask);
                        if (prot_ok && !special_mode) begin
                            d.prot_used = 1'b1;
                        end
                    end
                end
                ADDR_RES1, ADDR_RES2, ADDR_RES3, ADDR_RES4: begin
                    // Result registers ignore writes
                end
                default: begin
                    d.bresp = RESP_SLVERR;
                end
            endcase
        end

        // Control write aborts, clears flag, rearms; beats a same-cycle set
        if (start) begin
            d.flag = 1'b0;
            d.idx = 2'd0;
            d.st = ST_ARM;
        end

        // Reads sample registers in the cycle they are taken
        if (q.rvalid && axi_req.rready) begin
            d.rvalid = 1'b0;
        end
        if (rd_take) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            case (axi_req.araddr)
                ADDR_CTL: begin
                    d.rdata = ctl_word;
                end
                ADDR_OPT: begin
                    d.rdata = q.opt;
                end
                ADDR_RES1: begin
                    d.rdata = q.res[0];
                end
                ADDR_RES2: begin
                    d.rdata = q.res[1];
                end
                ADDR_RES3: begin
                    d.rdata = q.res[2];
                end
                ADDR_RES4: begin
                    d.rdata = q.res[3];
                end
                // Unmapped offsets answer an error with zero data
                default: begin
                    d.rdata = 8'h00;
                    d.rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    // State register
    // Reset values come from the package constants
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.sel <= CTL_RESET[3:0];
            q.scan <= CTL_RESET[CTL_SCAN_BIT];
            q.multi_input_select <= CTL_RESET[CTL_MULTI_INPUT_SELECT_BIT];
            q.flag <= CTL_RESET[CTL_FLAG_BIT];
            q.opt <= OPT_RESET;
            q.st <= ST_IDLE;
        end else begin
            q <= d;
        end
    end
endmodule

// ===== rtl/sar_core.sv
`timescale 1ns/10ps
module sar_core
    import sar_adc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    input wire logic decide,
    input wire logic comp_high,
    output logic [7:0] trial,
    output logic [7:0] result
);
    typedef struct packed {
        logic [7:0] sar;
        logic [7:0] mask;
    } sar_t;

    sar_t q;
    sar_t d;

    // One bit per decision, MSB first
    always_comb begin
        d = q;
        if (clear) begin
            d.sar = 8'h00;
            d.mask = SAR_MSB;
        end else if (decide) begin
            if (comp_high) begin
                d.sar = q.sar | q.mask;
            end
            d.mask = q.mask >> 1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign trial = q.sar | q.mask;
    assign result = q.sar;
endmodule

// ===== tb/adc_input_model.sv
`timescale 1ns/10ps
module adc_input_model
    import sar_adc_pkg::*;
(
    input wire logic aclk,
    input wire ana_out_t ana_out,
    output logic comp_high
);
    logic [7:0] held_q = 8'h00;
    // Level at each input; codes 12..14 are the references
    function automatic logic [7:0] level(input logic [3:0] ch);
        case (ch)
            4'hc: return 8'hff;
            4'hd: return 8'h00;
            4'he: return 8'h80;
            default: return {ch, 4'h3};
        endcase
    endfunction
    // Held charge follows the input only while the switch is closed
    always @(posedge aclk) begin
        if (ana_out.sample_on) begin
            held_q <= level(ana_out.chan);
        end
    end
    // Unpowered comparator gives nothing useful, so it reads low
    assign comp_high = ana_out.power_on && (held_q >= ana_out.dac);
endmodule

// ===== tb/adc_seq_props.sv
`timescale 1ns/10ps
module adc_seq_props
    import sar_adc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire axil_req_t axi_req,
    input wire axil_rsp_t axi_rsp,
    input wire logic comp_high,
    input wire logic rc_tick,
    input wire logic stop_mode,
    input wire logic special_mode,
    input wire ana_out_t ana_out,
    input wire logic cpu_resume_ok
);
    logic [4:0] samp_q;
    logic [4:0] samp_d;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Steps with the switch closed; RC mode steps only on ticks
    always_comb begin
        samp_d = 5'd0;
        if (ana_out.sample_on) begin
            samp_d = samp_q + 5'(!ana_out.rc_clock_sel || rc_tick);
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            samp_q <= 5'd0;
        end else begin
            samp_q <= samp_d;
        end
    end
    a_route_onehot: assert property (
        ana_out.route == 16'h0001 << ana_out.chan)
        else $error("route not one-hot of chan");
    a_sample_len: assert property (
        samp_q <= SAMPLE_CYC)
        else $error("sample window too long");
    a_power_off: assert property (
        !ana_out.power_on [*3]
        |-> !ana_out.sample_on && $stable(ana_out.dac))
        else $error("converter active while unpowered");
    a_stop_hold: assert property (
        stop_mode |-> !cpu_resume_ok [*3])
        else $error("resume during stop or exit wait");
    a_read_lat: assert property (
        axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read answer late");
    a_write_block: assert property (
        axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
        else $error("write taken under response");
    a_read_block: assert property (
        axi_rsp.rvalid |-> !axi_rsp.arready)
        else $error("read taken under response");
    a_rdata_width: assert property (
        axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_ctl_start: assert property (
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
        && axi_rsp.wready && axi_req.awaddr == ADDR_CTL
        && axi_req.wstrb[0] && ana_out.power_on && cpu_resume_ok
        && !stop_mode && !ana_out.rc_clock_sel
        |-> ##[1:4] ana_out.sample_on)
        else $error("no conversion after control write");
endmodule
bind sar_adc_sequencer adc_seq_props chk_u (
    .aclk(aclk), .aresetn(aresetn),
    .axi_req(axi_req), .axi_rsp(axi_rsp),
    .comp_high(comp_high), .rc_tick(rc_tick),
    .stop_mode(stop_mode), .special_mode(special_mode),
    .ana_out(ana_out), .cpu_resume_ok(cpu_resume_ok)
);

// ===== tb/sar_adc_sequencer_bench.sv
`timescale 1ns/10ps
module sar_adc_sequencer_bench
    import sar_adc_pkg::*;
;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
        logic [1:0] r;
    } row_t;
    logic aclk;
    logic aresetn;
    axil_req_t req;
    axil_rsp_t rsp;
    logic comp_high;
    logic rc_tick = 1'b0;
    logic stop_mode;
    logic special_mode;
    ana_out_t ana;
    logic resume_ok;
    int mismatches;
    int n_compared;
    int n;
    logic [31:0] rd;
    logic [1:0] rs;
    // Write or read, address, data, expected value, response
    row_t rows [0:9] = '{
        '{1'b1, ADDR_OPT, 8'hff, 8'h00, RESP_OKAY},
        '{1'b0, ADDR_OPT, 8'h00, 8'hfb, RESP_OKAY},
        '{1'b1, ADDR_OPT, 8'h80, 8'h00, RESP_OKAY},
        '{1'b0, ADDR_OPT, 8'h00, 8'hb3, RESP_OKAY},
        '{1'b0, ADDR_CTL, 8'h00, 8'h00, RESP_OKAY},
        '{1'b0, ADDR_RES4, 8'h00, 8'h00, RESP_OKAY},
        '{1'b1, ADDR_RES1, 8'hff, 8'h00, RESP_OKAY},
        '{1'b0, ADDR_RES1, 8'h00, 8'h00, RESP_OKAY},
        '{1'b0, 8'h18, 8'h00, 8'h00, RESP_SLVERR},
        '{1'b1, 8'h18, 8'h5a, 8'h00, RESP_SLVERR}
    };
    sar_adc_sequencer dut_u (
        .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
        .comp_high(comp_high), .rc_tick(rc_tick), .stop_mode(stop_mode),
        .special_mode(special_mode), .ana_out(ana),
        .cpu_resume_ok(resume_ok)
    );
    adc_input_model analog_u (
        .aclk(aclk), .ana_out(ana), .comp_high(comp_high)
    );
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // RC oscillator stand-in, one tick every second clock
    always @(posedge aclk) rc_tick <= ~rc_tick;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      output logic [1:0] r);
        logic aw_p;
        logic w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= {24'h0, d};
        req.bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (rsp.bvalid && !aw_p && !w_p) break;
            if (aw_p && rsp.awready) begin
                aw_p = 1'b0;
                req.awvalid <= 1'b0;
            end
            if (w_p && rsp.wready) begin
                w_p = 1'b0;
                req.wvalid <= 1'b0;
            end
        end
        r = rsp.bresp;
        req.bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        logic ar_p;
        ar_p = 1'b1;
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (rsp.rvalid && !ar_p) break;
            if (rsp.arready) begin
                ar_p = 1'b0;
                req.arvalid <= 1'b0;
            end
        end
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Polling takes reads, so stores must dodge them
    task automatic run(input logic [7:0] c, input logic [31:0] e);
        wr(ADDR_CTL, c, rs);
        rdr(ADDR_CTL, rd, rs);
        cmp(rd, {24'h0, c});
        n = 0;
        do begin
            rdr(ADDR_CTL, rd, rs);
            n++;
        end while (rd[7] !== 1'b1 && n < 400);
        cmp(rd, {24'h0, c | 8'h80});
        for (int i = 0; i < 4; i++) begin
            rdr(ADDR_RES1 + 8'(4 * i), rd, rs);
            cmp(rd, {24'h0, e[31 - 8 * i -: 8]});
        end
        $display("ctl %h sequence checked", c);
    endtask
    task automatic count_samples(input int cycles);
        n = 0;
        repeat (cycles) begin
            @(posedge aclk);
            if (ana.sample_on === 1'b1) n++;
        end
    endtask
    task automatic stop_exit(input int lo, input int hi);
        stop_mode <= 1'b1;
        repeat (10) @(posedge aclk);
        stop_mode <= 1'b0;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (resume_ok !== 1'b1 && n < 5000);
        cmp(32'(n >= lo && n <= hi), 32'h1);
        $display("stop exit after %0d cycles", n);
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Cuts a hang short well past the expected run length
    initial begin
        repeat (60000) @(posedge aclk);
        mismatches++;
        final_report();
    end
    initial begin
        req = '0;
        req.wstrb = 4'hf;
        aresetn = 1'b0;
        stop_mode = 1'b0;
        special_mode = 1'b0;
        mismatches = 0;
        n_compared = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Starts inside the protect window on purpose
        foreach (rows[i]) begin
            rd = 32'h0;
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d, rs);
            end else begin
                rdr(rows[i].a, rd, rs);
            end
            cmp({rs, rd[29:0]}, {rows[i].r, 22'h0, rows[i].e});
        end
        $display("register table checked");
        repeat (12500) @(posedge aclk);
        run(8'h02, 32'h23232323);
        run(8'h1c, 32'hff0080f3);
        run(8'h15, 32'h43536373);
        run(8'h21, 32'h13131313);
        count_samples(200);
        cmp(32'(n > 0), 32'h1);
        run(8'h06, 32'h63636363);
        wr(ADDR_OPT, 8'h00, rs);
        wr(ADDR_CTL, 8'h02, rs);
        count_samples(100);
        cmp(32'(n), 32'h0);
        $display("power off checked");
        wr(ADDR_OPT, 8'hc0, rs);
        repeat (12500) @(posedge aclk);
        cmp(32'(ana.rc_clock_sel), 32'h1);
        run(8'h03, 32'h33333333);
        stop_exit(3990, 4010);
        special_mode <= 1'b1;
        wr(ADDR_OPT, 8'h80, rs);
        rdr(ADDR_OPT, rd, rs);
        cmp(rd, 32'h80);
        stop_exit(1, 8);
        // Second reset in mid-run: power, control and results clear
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cmp(32'(ana.power_on), 32'h0);
        rdr(ADDR_CTL, rd, rs);
        cmp(rd, {24'h0, CTL_RESET});
        rdr(ADDR_RES1, rd, rs);
        cmp(rd, 32'h0);
        $display("mid-run reset checked");
        final_report();
    end
endmodule
